// ### cgc_device.sv
// Device end: control bank behind the two-wire link, clock output gating
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
// Function
// - Byte write: address, command, data, three acks
// - Byte read: repeated start, one byte, host nacks
// - Acknowledge only a matching seven-bit address
// - Command code follows address and is acknowledged
// - Byte 0 bits 7..1 enable serial pairs
// - Byte 1 enables free-running bus0, 48 MHz, reference
// - Byte 1 enables dot pair, cpu pairs
// - Byte 1 bit 0 turns spread on
// - Byte 1 bit 3 selects spread profile
// - Byte 2 enables bus and free-running outputs
// - Byte 3 selects stoppable serial pairs
// - Byte 4 selects stoppable free-running outputs
// - Byte 4 bit 6 dot power-down drive
// - Byte 5 bit 7 stopped serial drive
// - Byte 5 bit 3 serial power-down drive
// - Byte 5 bits 2..0 cpu power-down drive
// - Respond only to address D2h for writes and D3h for reads
// - Command bit 7 selects single; offset below
// - Stops and resumes only at clean boundaries
module cgc_device (
  input wire logic mclk,
  input wire logic rst,
  cgc_link_if.device link,
  input wire logic power_down_input,
  input wire logic software_bus_clock_stop,
  input wire logic stop_boundary,
  output logic [6:1] serial_ref_clock_pair_oe,
  output logic [7:1] serial_ref_clock_pair_run,
  output logic cpu2_or_serial7_pair_oe,
  output logic [1:0] cpu_pair_oe,
  output logic cpu_dot_run,
  output logic dot_clock_pair_oe,
  output logic [5:0] bus_clock_oe,
  output logic bus_clock_run,
  output logic [2:0] free_running_bus_clock_oe,
  output logic [2:0] free_running_bus_clock_run,
  output logic usb48_oe,
  output logic ref_oe,
  output logic spread_on,
  output logic spread_center,
  output logic power_down_state
);
  import cgc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] s3;
  logic [2:0] lvl;
  logic [1:0] lvl_d;
  wire [2:0] pins = {power_down_input, link.scl, link.sda};

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s1 <= 3'h3;
      s2 <= 3'h3;
      s3 <= 3'h3;
      lvl <= 3'h3;
      lvl_d <= 2'h3;
    end
    else
    begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      // A level moves only once the last two stages agree
      lvl <= (s2 & s3) | (lvl & (s2 | s3));
      lvl_d <= lvl[1:0];
    end
  end

  wire scl_f = lvl[1];
  wire sda_f = lvl[0];
  wire scl_rise = scl_f & ~lvl_d[1];
  wire scl_fall = ~scl_f & lvl_d[1];
  wire start_seen = scl_f & lvl_d[1] & ~sda_f & lvl_d[0];
  wire stop_seen = scl_f & lvl_d[1] & sda_f & ~lvl_d[0];

  // ----------------------------------------------------------------
  // Control bytes
  // ----------------------------------------------------------------
  logic [7:0] regs [0:5];
  cgc_dstate_t state;
  logic [7:0] shift;
  logic [3:0] bitn;
  logic [1:0] byte_no;
  logic [7:0] cmd;
  logic rd_mode;
  logic sda_drive;

  function automatic logic [7:0] reg_rd(input logic [6:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    if (ofs < CGC_NUM_REGS)
      v = regs[ofs[2:0]];
    return v;
  endfunction

  wire [6:0] ofs = cmd[6:0];
  wire [7:0] rd_byte = reg_rd(ofs);
  wire single = cmd[CGC_CMD_SINGLE];
  wire wr_hit = scl_fall & (state == CGC_D_RECV) & (bitn == CGC_BYTE_BITS)
    & (byte_no == 2'h2) & single & (ofs < CGC_NUM_REGS);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      regs[0] <= CGC_RST_SRC_EN;
      regs[1] <= CGC_RST_MISC;
      regs[2] <= CGC_RST_BUS_EN;
      regs[3] <= CGC_RST_SRC_STP;
      regs[4] <= CGC_RST_DOT_FRB;
      regs[5] <= CGC_RST_DRV;
    end
    else if (wr_hit)
      regs[ofs[2:0]] <= shift;
  end

  // ----------------------------------------------------------------
  // Serial slave engine
  // ----------------------------------------------------------------
  assign link.dev_scl_out = 1'b0;
  assign link.dev_scl_oe = 1'b0;
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = sda_drive;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= CGC_D_IDLE;
      shift <= 8'h0;
      bitn <= 4'h0;
      byte_no <= 2'h0;
      cmd <= 8'h0;
      rd_mode <= 1'b0;
      sda_drive <= 1'b0;
    end
    else if (start_seen)
    begin
      // Repeated start keeps the command for the read that follows
      state <= CGC_D_RECV;
      bitn <= 4'h0;
      byte_no <= 2'h0;
      sda_drive <= 1'b0;
    end
    else if (stop_seen)
    begin
      state <= CGC_D_IDLE;
      sda_drive <= 1'b0;
    end
    else
    begin
      case (state)
        CGC_D_IDLE:
          sda_drive <= 1'b0;
        CGC_D_RECV:
        begin
          if (scl_rise && bitn != CGC_BYTE_BITS)
          begin
            shift <= {shift[6:0], sda_f};
            bitn <= bitn + 1'b1;
          end
          else if (scl_fall && bitn == CGC_BYTE_BITS)
          begin
            sda_drive <= 1'b1;
            state <= CGC_D_ACK;
            case (byte_no)
              2'h0:
              begin
                rd_mode <= shift[0];
                if (shift[7:1] != CGC_DEV_ADDR)
                begin
                  sda_drive <= 1'b0;
                  state <= CGC_D_IDLE;
                end
              end
              2'h1: cmd <= shift;
              2'h2: ;
              default:
              begin
                // Only one data byte per write; the rest is refused
                sda_drive <= 1'b0;
                state <= CGC_D_IDLE;
              end
            endcase
          end
        end
        CGC_D_ACK:
        begin
          if (scl_fall)
          begin
            bitn <= 4'h0;
            if (rd_mode)
            begin
              shift <= rd_byte << 1;
              sda_drive <= ~rd_byte[7];
              bitn <= 4'h1;
              state <= CGC_D_SEND;
            end
            else
            begin
              sda_drive <= 1'b0;
              byte_no <= byte_no + 1'b1;
              state <= CGC_D_RECV;
            end
          end
        end
        CGC_D_SEND:
        begin
          if (scl_fall)
          begin
            if (bitn == CGC_BYTE_BITS)
            begin
              sda_drive <= 1'b0;
              state <= CGC_D_MACK;
            end
            else
            begin
              sda_drive <= ~shift[7];
              shift <= shift << 1;
              bitn <= bitn + 1'b1;
            end
          end
        end
        CGC_D_MACK:
        begin
          // Block reads are not offered: ack or nack ends the byte
          if (scl_rise)
            state <= CGC_D_IDLE;
        end
        default: state <= CGC_D_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output gating
  // ----------------------------------------------------------------
  // Stop and power-down move only at a clock-low boundary, no runt pulses
  logic stop_act;
  logic pd_act;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stop_act <= 1'b0;
      pd_act <= 1'b0;
    end
    else if (stop_boundary)
    begin
      stop_act <= software_bus_clock_stop;
      pd_act <= lvl[2];
    end
  end

  wire [7:0] r0 = regs[0];
  wire [7:0] r1 = regs[1];
  wire [7:0] r2 = regs[2];
  wire [7:0] r3 = regs[3];
  wire [7:0] r4 = regs[4];
  wire [7:0] r5 = regs[5];
  wire [7:1] src_stopped = r3[7:1] & {7{stop_act}};
  wire [7:1] src_hiz = (src_stopped & {7{r5[CGC_B5_SRCSTP]}})
    | {7{pd_act & r5[CGC_B5_SRCPD]}};
  wire [2:0] frb_stp = r4[CGC_B4_FRB0 +: 3];
  wire [2:0] frb_en = {r2[1:0], r1[CGC_B1_FRB0]};

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      serial_ref_clock_pair_oe <= 6'h0;
      serial_ref_clock_pair_run <= 7'h0;
      cpu2_or_serial7_pair_oe <= 1'b0;
      cpu_pair_oe <= 2'h0;
      cpu_dot_run <= 1'b0;
      dot_clock_pair_oe <= 1'b0;
      bus_clock_oe <= 6'h0;
      bus_clock_run <= 1'b0;
      free_running_bus_clock_oe <= 3'h0;
      free_running_bus_clock_run <= 3'h0;
      usb48_oe <= 1'b0;
      ref_oe <= 1'b0;
      spread_on <= 1'b0;
      spread_center <= 1'b0;
      power_down_state <= 1'b0;
    end
    else
    begin
      serial_ref_clock_pair_oe <= r0[6:1] & ~src_hiz[6:1];
      serial_ref_clock_pair_run <= ~src_stopped & {7{~pd_act}};
      cpu2_or_serial7_pair_oe <= r0[CGC_B0_CPU2] & ~src_hiz[7]
        & ~(pd_act & r5[2]);
      cpu_pair_oe <= {r1[CGC_B1_CPU1], r1[CGC_B1_CPU0]}
        & ~({2{pd_act}} & r5[1:0]);
      cpu_dot_run <= ~pd_act;
      dot_clock_pair_oe <= r1[CGC_B1_DOT]
        & ~(pd_act & r4[CGC_B4_DOTPD]);
      bus_clock_oe <= r2[7:2];
      bus_clock_run <= ~stop_act & ~pd_act;
      free_running_bus_clock_oe <= frb_en;
      free_running_bus_clock_run <= ~(frb_stp & {3{stop_act}})
        & {3{~pd_act}};
      usb48_oe <= r1[CGC_B1_USB];
      ref_oe <= r1[CGC_B1_REF];
      spread_on <= r1[CGC_B1_SSEN];
      spread_center <= r1[CGC_B1_SPROF];
      power_down_state <= pd_act;
    end
  end
endmodule

// ### cgc_pkg.sv
// Shared constants and types for the clock generator control bank
package cgc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CGC_CLK_NS = 5;
  // Faster than a real bus so a full run stays short
  localparam int CGC_SCL_PERIOD_NS = 1000;
  localparam int CGC_QTR_CYC = CGC_SCL_PERIOD_NS / (4 * CGC_CLK_NS);
  localparam int CGC_QTR_W = 10;
  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  localparam logic [6:0] CGC_DEV_ADDR = 7'h69;
  localparam logic CGC_DIR_RD = 1'b1;
  localparam logic CGC_DIR_WR = 1'b0;
  localparam int CGC_CMD_SINGLE = 7;
  localparam logic [3:0] CGC_BYTE_BITS = 4'h8;
  // ----------------------------------------------------------------
  // Control bytes
  // ----------------------------------------------------------------
  localparam logic [6:0] CGC_NUM_REGS = 7'h06;
  localparam logic [6:0] CGC_OFS_SRC_EN = 7'h00;
  localparam logic [6:0] CGC_OFS_MISC = 7'h01;
  localparam logic [6:0] CGC_OFS_BUS_EN = 7'h02;
  localparam logic [6:0] CGC_OFS_SRC_STP = 7'h03;
  localparam logic [6:0] CGC_OFS_DOT_FRB = 7'h04;
  localparam logic [6:0] CGC_OFS_DRV = 7'h05;
  localparam logic [7:0] CGC_RST_SRC_EN = 8'hff;
  localparam logic [7:0] CGC_RST_MISC = 8'hf6;
  localparam logic [7:0] CGC_RST_BUS_EN = 8'hff;
  localparam logic [7:0] CGC_RST_SRC_STP = 8'h00;
  localparam logic [7:0] CGC_RST_DOT_FRB = 8'h07;
  localparam logic [7:0] CGC_RST_DRV = 8'h00;
  localparam int CGC_B0_CPU2 = 7;
  localparam int CGC_B1_FRB0 = 7;
  localparam int CGC_B1_DOT = 6;
  localparam int CGC_B1_USB = 5;
  localparam int CGC_B1_REF = 4;
  localparam int CGC_B1_SPROF = 3;
  localparam int CGC_B1_CPU1 = 2;
  localparam int CGC_B1_CPU0 = 1;
  localparam int CGC_B1_SSEN = 0;
  localparam int CGC_B4_DOTPD = 6;
  localparam int CGC_B4_FRB0 = 3;
  localparam int CGC_B5_SRCSTP = 7;
  localparam int CGC_B5_SRCPD = 3;
  // ----------------------------------------------------------------
  // Host command registers (Avalon byte addresses)
  // ----------------------------------------------------------------
  localparam int CGC_AV_W = 4;
  localparam logic [3:0] CGC_AV_CMD = 4'h0;
  localparam logic [3:0] CGC_AV_STAT = 4'h4;
  localparam int CGC_CMD_OFS_LO = 8;
  localparam int CGC_CMD_RD = 16;
  localparam int CGC_ST_BUSY = 8;
  localparam int CGC_ST_NACK = 9;
  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CGC_D_IDLE = 3'b000,
    CGC_D_RECV = 3'b001,
    CGC_D_ACK = 3'b010,
    CGC_D_SEND = 3'b011,
    CGC_D_MACK = 3'b100
  } cgc_dstate_t;
  typedef enum logic [2:0] {
    CGC_H_IDLE = 3'b000,
    CGC_H_START = 3'b001,
    CGC_H_TX = 3'b010,
    CGC_H_RX = 3'b011,
    CGC_H_STOP = 3'b100
  } cgc_hstate_t;
  typedef enum logic [1:0] {
    CGC_S_AW = 2'b00,
    CGC_S_CMD = 2'b01,
    CGC_S_WD = 2'b10,
    CGC_S_AR = 2'b11
  } cgc_step_t;
endpackage

// ### cgc_link_if.sv
// Two-wire link between the control bank and its host
`timescale 1ns/1ps
interface cgc_link_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-up: a released line reads high
  assign scl = (host_scl_oe ? host_scl_out : 1'b1)
    & (dev_scl_oe ? dev_scl_out : 1'b1);
  assign sda = (host_sda_oe ? host_sda_out : 1'b1)
    & (dev_sda_oe ? dev_sda_out : 1'b1);
  modport device (input scl, input sda, output dev_scl_out,
    output dev_scl_oe, output dev_sda_out, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_out,
    output host_scl_oe, output host_sda_out, output host_sda_oe);
endinterface

// ### cgc_host.sv
// Host end: Avalon command registers driving single-byte transfers
`timescale 1ns/1ps
module cgc_host (
  input wire logic mclk,
  input wire logic rst,
  cgc_link_if.host link,
  input wire logic [cgc_pkg::CGC_AV_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import cgc_pkg::*;

  logic served;
  logic [31:0] cmd;
  logic [31:0] merged;
  logic busy;
  logic nack;
  logic [7:0] rdata;
  logic [CGC_QTR_W-1:0] qcnt;
  logic tick;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [7:0] shift;
  logic scl_rel;
  logic sda_rel;
  cgc_hstate_t state;
  cgc_step_t step;

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~served;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      merged[i*8 +: 8] = avs_byteenable[i] ? avs_writedata[i*8 +: 8]
        : cmd[i*8 +: 8];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      served <= 1'b0;
    else
      served <= (avs_read | avs_write) & ~served;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      avs_readdata <= 32'h0;
    else if (avs_read & ~served)
    begin
      case (avs_address)
        CGC_AV_CMD: avs_readdata <= cmd;
        CGC_AV_STAT: avs_readdata <= {22'h0, nack, busy, rdata};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // Command writes while busy are dropped so a transfer is never torn
  wire go = avs_write & served & (avs_address == CGC_AV_CMD) & ~busy;

  always_ff @(posedge mclk)
  begin
    if (rst)
      cmd <= 32'h0;
    else if (go)
      cmd <= merged;
  end

  // ----------------------------------------------------------------
  // Quarter-bit enable
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst | tick)
      qcnt <= '0;
    else
      qcnt <= qcnt + 1'b1;
  end
  assign tick = (qcnt == CGC_QTR_W'(CGC_QTR_CYC - 1));

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  assign link.host_scl_out = 1'b0;
  assign link.host_sda_out = 1'b0;
  assign link.host_scl_oe = ~scl_rel;
  assign link.host_sda_oe = ~sda_rel;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= CGC_H_IDLE;
      step <= CGC_S_AW;
      busy <= 1'b0;
      nack <= 1'b0;
      rdata <= 8'h0;
      phase <= 2'h0;
      bitn <= 4'h0;
      shift <= 8'h0;
      scl_rel <= 1'b1;
      sda_rel <= 1'b1;
    end
    else if (go)
    begin
      busy <= 1'b1;
      nack <= 1'b0;
      step <= CGC_S_AW;
      shift <= {CGC_DEV_ADDR, CGC_DIR_WR};
      phase <= 2'h0;
      state <= CGC_H_START;
    end
    else if (tick)
    begin
      phase <= phase + 1'b1;
      case (state)
        CGC_H_IDLE:
          phase <= 2'h0;
        CGC_H_START:
        begin
          // Also serves as repeated start: SCL low, SDA up, SCL up, SDA down
          case (phase)
            2'h0: sda_rel <= 1'b1;
            2'h1: scl_rel <= 1'b1;
            2'h2: sda_rel <= 1'b0;
            default:
            begin
              scl_rel <= 1'b0;
              bitn <= 4'h0;
              state <= CGC_H_TX;
            end
          endcase
        end
        CGC_H_TX, CGC_H_RX:
        begin
          case (phase)
            2'h0:
            begin
              if (state == CGC_H_TX)
                sda_rel <= (bitn == CGC_BYTE_BITS) | shift[7];
              else
                sda_rel <= 1'b1;
            end
            2'h1: scl_rel <= 1'b1;
            2'h2:
            begin
              if (bitn != CGC_BYTE_BITS)
                shift <= {shift[6:0], link.sda};
              else if (state == CGC_H_TX)
                nack <= link.sda;
            end
            default:
            begin
              scl_rel <= 1'b0;
              bitn <= bitn + 1'b1;
              if (bitn == CGC_BYTE_BITS)
              begin
                bitn <= 4'h0;
                state <= CGC_H_TX;
                if (state == CGC_H_RX)
                begin
                  rdata <= shift;
                  state <= CGC_H_STOP;
                end
                else if (nack)
                  state <= CGC_H_STOP;
                else
                begin
                  case (step)
                    CGC_S_AW:
                    begin
                      step <= CGC_S_CMD;
                      shift <= {1'b1, cmd[CGC_CMD_OFS_LO +: 7]};
                    end
                    CGC_S_CMD:
                    begin
                      if (cmd[CGC_CMD_RD])
                      begin
                        step <= CGC_S_AR;
                        shift <= {CGC_DEV_ADDR, CGC_DIR_RD};
                        state <= CGC_H_START;
                      end
                      else
                      begin
                        step <= CGC_S_WD;
                        shift <= cmd[7:0];
                      end
                    end
                    CGC_S_AR: state <= CGC_H_RX;
                    default: state <= CGC_H_STOP;
                  endcase
                end
              end
            end
          endcase
        end
        CGC_H_STOP:
        begin
          case (phase)
            2'h0: sda_rel <= 1'b0;
            2'h1: scl_rel <= 1'b1;
            2'h2: sda_rel <= 1'b1;
            default:
            begin
              busy <= 1'b0;
              state <= CGC_H_IDLE;
            end
          endcase
        end
        default: state <= CGC_H_IDLE;
      endcase
    end
  end
endmodule

// ### cgc_link_properties.sv
// Wire-level checks on the two-wire link between host and device
`timescale 1ns/1ps
module cgc_link_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe
);
  import cgc_pkg::*;
  int hi_cnt;
  int lo_cnt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Run lengths of the clock line
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    hi_cnt <= (rst || !scl) ? 0 : hi_cnt + 1;
  end
  always_ff @(posedge mclk)
  begin
    lo_cnt <= (rst || scl) ? 0 : lo_cnt + 1;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_out)
    else $error("device drives data line high");
  chk_no_clock_pull: assert property (!dev_scl_oe)
    else $error("device pulls the clock line");
  chk_dev_stable: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data changed while clock high");
  chk_dev_grab_low: assert property ($rose(dev_sda_oe) |-> !scl [*8])
    else $error("device took data line without setup");
  chk_dev_drop_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device released data line while clock high");
  chk_start_hold: assert property ($fell(sda) && scl |-> scl [*8])
    else $error("start condition not held");
  chk_stop_release: assert property ($rose(sda) && scl |-> ##1 !dev_sda_oe [*8])
    else $error("device still pulls after stop");
  chk_clock_high_min: assert property ($fell(scl) |-> hi_cnt >= CGC_QTR_CYC)
    else $error("clock high phase too short");
  chk_clock_low_max: assert property (lo_cnt < 4 * CGC_QTR_CYC)
    else $error("clock held low too long");
endmodule

// ### clock_gen_control_registers_tb_top.sv
// Self-checking bench joining host and device ends of the control bank
`timescale 1ns/1ps
module clock_gen_control_registers_tb_top;
  import cgc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic pd_in = 1'b0;
  logic sw_stop = 1'b0;
  logic bnd = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic want = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic [6:1] sr_oe;
  logic [7:1] sr_run;
  logic [1:0] cpu_oe;
  logic [5:0] bus_oe;
  logic [2:0] fr_oe;
  logic [2:0] fr_run;
  logic c2_oe, cd_run, dot_oe, bus_run, usb_oe, ref_oe, ss_on, ss_c, pd_st;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  logic [22:0] x1;
  logic [7:0] d;
  logic [7:0] d3;
  int failures = 0;
  int n_checks = 0;
  wire [22:0] oe_v = {sr_oe, c2_oe, cpu_oe, dot_oe, bus_oe, fr_oe, usb_oe,
    ref_oe, ss_on, ss_c};
  wire [11:0] run_v = {sr_run, cd_run, bus_run, fr_run};
  always #2.5 mclk = ~mclk;
  cgc_link_if link();
  cgc_host cgc_host_inst (.mclk(mclk), .rst(rst), .link(link),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq));
  cgc_device cgc_device_inst (.mclk(mclk), .rst(rst), .link(link),
    .power_down_input(pd_in), .software_bus_clock_stop(sw_stop),
    .stop_boundary(bnd), .serial_ref_clock_pair_oe(sr_oe),
    .serial_ref_clock_pair_run(sr_run), .cpu2_or_serial7_pair_oe(c2_oe),
    .cpu_pair_oe(cpu_oe), .cpu_dot_run(cd_run), .dot_clock_pair_oe(dot_oe),
    .bus_clock_oe(bus_oe), .bus_clock_run(bus_run),
    .free_running_bus_clock_oe(fr_oe), .free_running_bus_clock_run(fr_run),
    .usb48_oe(usb_oe), .ref_oe(ref_oe), .spread_on(ss_on),
    .spread_center(ss_c), .power_down_state(pd_st));
  cgc_link_properties cgc_link_properties_inst (.mclk(mclk), .rst(rst),
    .scl(link.scl), .sda(link.sda), .dev_scl_oe(link.dev_scl_oe),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] ex);
    n_checks++;
    if (seen !== ex)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Request held until the edge where waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] v, input logic n, input logic [63:0] ex);
    if (n)
      exp_q.push_back(ex);
    want <= n;
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    do
      @(posedge mclk);
    while (wreq !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h100;
    while (s[CGC_ST_BUSY] !== 1'b0)
    begin
      repeat (200) @(posedge mclk);
      bus(1'b0, CGC_AV_STAT, 32'h0, 1'b0, 64'h0);
      s = rdata;
    end
  endtask
  task automatic put(input logic [6:0] o, input logic [7:0] v);
    bus(1'b1, CGC_AV_CMD, {17'h0, o, v}, 1'b0, 64'h0);
    wait_idle();
  endtask
  task automatic boundary();
    bnd <= 1'b1;
    @(posedge mclk);
    bnd <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge mclk)
    if (want && rd && wreq === 1'b0 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check("readdata", rdata & e[63:32], e[31:0]);
    end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    d = 8'($urandom(5));
    d = 8'($urandom());
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (10) @(posedge mclk);
    check("enables", oe_v, 23'h7ffffc);
    check("runs", {run_v, pd_st}, 13'h1ffe);
    put(CGC_OFS_MISC, d);
    bus(1'b0, CGC_AV_STAT, 32'h0, 1'b1, {32'h300, 32'h0});
    x1 = {7'h7f, d[2:1], d[6], 6'h3f, 2'b11, d[7], d[5], d[4], d[0], d[3]};
    check("byte1", oe_v, x1);
    bus(1'b1, CGC_AV_CMD, {15'h0, 2'b10, CGC_OFS_MISC, 8'h0}, 1'b0, 64'h0);
    wait_idle();
    bus(1'b0, CGC_AV_STAT, 32'h0, 1'b1, {32'h3ff, 24'h0, d});
    check("after read", oe_v, x1);
    bus(1'b0, 4'h8, 32'h0, 1'b1, {32'hffffffff, 32'h0});
    d3 = 8'($urandom());
    put(CGC_OFS_SRC_STP, {d3[7:1], 1'b0});
    put(CGC_OFS_DOT_FRB, 8'h7f);
    put(CGC_OFS_DRV, 8'h8f);
    check("idle oe", oe_v, x1);
    sw_stop <= 1'b1;
    repeat (8) @(posedge mclk);
    check("no boundary", run_v, 12'hfff);
    boundary();
    check("stopped", run_v, {~d3[7:1], 5'b10000});
    check("stop drive", oe_v, {~d3[6:1], ~d3[7], x1[15:0]});
    pd_in <= 1'b1;
    repeat (8) @(posedge mclk);
    boundary();
    check("pd drive", {oe_v, pd_st}, {10'h0, x1[12:0], 1'b1});
    sw_stop <= 1'b0;
    pd_in <= 1'b0;
    repeat (8) @(posedge mclk);
    boundary();
    check("resumed", {run_v, pd_st}, 13'h1ffe);
    check("resumed oe", oe_v, x1);
    conclude();
  end
  initial
  begin
    repeat (80000) @(posedge mclk);
    failures++;
    conclude();
  end
endmodule
